//--- logic/status_pkg.sv
// Shared constants and types for the status-reporting command core.
// Assumes one clock domain; commands arrive already parsed from the bus controller.
package status_pkg;

  // Standard event status bit positions
  localparam int unsigned EV_POWER_ON   = 7;
  localparam int unsigned EV_CMD_ERR    = 5;
  localparam int unsigned EV_EXEC_ERR   = 4;
  localparam int unsigned EV_DEV_ERR    = 3;
  localparam int unsigned EV_QUERY_ERR  = 2;
  localparam int unsigned EV_OP_DONE    = 0;
  localparam logic [7:0]  EV_USED_MASK  = 8'hbd;   // Bits 6 and 1 unused
  localparam logic [7:0]  EV_STATUS_RESET = 8'h80; // Power-on pending after reset
  localparam logic [7:0]  EV_MASK_RESET   = 8'h00;

  // Status byte bit positions
  localparam int unsigned SB_OPER       = 7;
  localparam int unsigned SB_MASTER     = 6;
  localparam int unsigned SB_EVENT_SUM  = 5;
  localparam int unsigned SB_MSG_AVAIL  = 4;
  localparam int unsigned SB_QUES       = 3;
  localparam int unsigned SB_ERR_QUEUE  = 2;
  localparam logic [7:0]  SRQ_WRITABLE  = 8'hbf;   // Bit 6 of the mask cannot be set
  localparam logic [7:0]  SRQ_MASK_RESET = 8'h00;

  // Error number class boundaries
  localparam logic [9:0]  ERR_CLASS_1 = 10'd100;
  localparam logic [9:0]  ERR_CLASS_2 = 10'd200;
  localparam logic [9:0]  ERR_CLASS_3 = 10'd300;
  localparam logic [9:0]  ERR_CLASS_4 = 10'd400;
  localparam logic [9:0]  ERR_CLASS_5 = 10'd500;

  // Response characters and identification layout
  localparam logic [7:0]  ASCII_ONE    = 8'h31;
  localparam int unsigned IDENT_LEN    = 47;

  typedef enum logic [3:0] {
    CMD_CLEAR_STATUS       = 4'h0,
    CMD_EVENT_MASK_WRITE   = 4'h1,
    CMD_EVENT_MASK_QUERY   = 4'h2,
    CMD_EVENT_STATUS_QUERY = 4'h3,
    CMD_IDENT_QUERY        = 4'h4,
    CMD_OPC_SET            = 4'h5,
    CMD_OPC_QUERY          = 4'h6,
    CMD_RESET              = 4'h7,
    CMD_SRQ_MASK_WRITE     = 4'h8,
    CMD_SRQ_MASK_QUERY     = 4'h9,
    CMD_STATUS_BYTE_QUERY  = 4'ha,
    CMD_SELF_TEST          = 4'hb,
    CMD_SERIAL_POLL        = 4'hc
  } cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_OPC_WAIT  = 2'b01,
    ST_TEST_WAIT = 2'b11,
    ST_IDENT     = 2'b10
  } ctl_state_t;

endpackage

//--- logic/ident_if.sv
// Carrier between the command core and the identification string streamer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ident_if;
  logic       start;
  logic       fw_updated;
  logic       valid;
  logic [7:0] data;
  logic       last;

  modport source (input start, input fw_updated, output valid, output data, output last);
  modport sink   (output start, output fw_updated, input valid, input data, input last);
endinterface

//--- logic/ident_streamer.sv
// Streams the identification answer one character per cycle.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/1ps
module ident_streamer
  import status_pkg::*;
#(
  parameter logic [8*8-1:0]  MAKER_TEXT = "MAKER   ", // Arbitrary neutral value
  parameter logic [8*16-1:0] MODEL_TEXT = "MODEL-0000-0000 ",
  parameter logic [8*15-1:0] MFG_TEXT   = "01012000-000001",
  parameter logic [7:0]      REV_MAJOR  = 8'h31,
  parameter logic [15:0]     REV_MINOR  = 16'h3030
)
(
  // Clock and reset
  input wire logic         core_clk,
  input wire logic         rst_n,
  // Link to the command core
  ident_if.source          link
);

  typedef struct packed {
    logic       busy;
    logic [5:0] idx;
    logic       valid;
    logic [7:0] data;
    logic       last;
  } stream_regs_t;

  stream_regs_t cur;
  stream_regs_t next_cur;
  logic [8*IDENT_LEN-1:0] text;

  // Whole answer: maker, model, manufacturing data, firmware revision
  always_comb
  begin
    text = {MAKER_TEXT, 8'h2c, MODEL_TEXT, 8'h2c, MFG_TEXT, 8'h2c,
            (link.fw_updated ? 8'h76 : 8'h56), REV_MAJOR, 8'h2e, REV_MINOR}; // [RULE11] [RULE12]
  end

  // Walk the characters; data comes from flops
  always_comb
  begin
    next_cur = cur;
    next_cur.valid = 1'b0;
    next_cur.last = 1'b0;
    if (!cur.busy && link.start)
    begin
      next_cur.busy = 1'b1;
      next_cur.idx = '0;
    end
    else if (cur.busy)
    begin
      next_cur.valid = 1'b1;
      next_cur.data = text[8*(IDENT_LEN-1-int'(cur.idx)) +: 8]; // [RULE11]
      next_cur.last = (int'(cur.idx) == IDENT_LEN-1);
      next_cur.idx = cur.idx + 6'h01;
      if (int'(cur.idx) == IDENT_LEN-1)
        next_cur.busy = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign link.valid = cur.valid;
  assign link.data  = cur.data;
  assign link.last  = cur.last;

endmodule

//--- logic/ieee488_status_reporting.sv
// Status-reporting core: event status, masks, status byte and common commands.
// Assumes parsed commands from a bus controller and same-clock event inputs.
`timescale 1ns/1ps

// Functional notes
// [RULE1] Clear-status zeroes event status, status byte, error queue; masks untouched.
// [RULE2] Eight-bit event enable mask, any value 0..255, reads back, resets to zero.
// [RULE3] Event summary bit 5 is OR of event status ANDed with enable mask.
// [RULE4] Event bits: power-on 7, command 5, exec 4, device 3, query 2, done 0.
// [RULE5] Event status query returns the value then clears the register.
// [RULE6] Error 1xx sets command error; error 2xx sets execution error.
// [RULE7] Error 3xx sets device error; error 4xx sets query error.
// [RULE8] Regulation error with its questionable bit set also sets device error.
// [RULE9] Operation-complete command sets bit 0 after pending work; commands continue.
// [RULE10] Operation-complete query answers ASCII one after pending work, blocking commands.
// [RULE11] Identification answer: maker, model, manufacturing data, firmware revision.
// [RULE12] Revision starts with V for factory firmware, v for updated firmware.
// [RULE13] First event status query after power-up shows the power-on bit.
// [RULE14] Status byte query returns status byte with master summary, clears nothing.
// [RULE15] Reset command turns output off, zero volts, minimum current.
// [RULE16] Self-test query answers 0 on pass, 1 on fail.
// [RULE17] Status byte: oper 7, master 6, event 5, message 4, ques 3, errors 2.
// [RULE18] Bit 6 is OR of enabled status bits; poll copy clears on serial poll.
// [RULE19] Unused event status bits read zero and never feed the summary.
module ieee488_status_reporting
  import status_pkg::*;
#(
  parameter int unsigned     ERR_CNT_W  = 4,
  parameter logic [8*8-1:0]  MAKER_TEXT = "MAKER   ", // Arbitrary neutral value
  parameter logic [8*16-1:0] MODEL_TEXT = "MODEL-0000-0000 ",
  parameter logic [8*15-1:0] MFG_TEXT   = "01012000-000001",
  parameter logic [7:0]      REV_MAJOR  = 8'h31,
  parameter logic [15:0]     REV_MINOR  = 16'h3030
)
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  // Command port
  input  wire logic                 cmd_valid,
  input  wire status_pkg::cmd_t     cmd_code,
  input  wire logic [7:0]           cmd_arg,
  output wire logic                 cmd_ready,
  // Response port
  output wire logic                 resp_valid,
  output wire logic [7:0]           resp_data,
  output wire logic                 resp_text,
  output wire logic                 resp_last,
  // Error and regulation events
  input  wire logic                 err_valid,
  input  wire logic [9:0]           err_code,
  input  wire logic                 err_read,
  input  wire logic                 reg_err_valid,
  input  wire logic                 ques_reg_bit,
  // Summaries and progress from neighbouring logic
  input  wire logic                 oper_summary,
  input  wire logic                 ques_summary,
  input  wire logic                 msg_available,
  input  wire logic                 ops_pending,
  input  wire logic                 fw_updated,
  // Actions toward the rest of the supply
  output wire logic                 clear_oper_ques,
  output wire logic                 reset_levels,
  output wire logic                 selftest_start,
  input  wire logic                 selftest_done,
  input  wire logic                 selftest_fail,
  // Service request
  output wire logic                 service_request
);

  typedef struct packed {
    ctl_state_t           state;
    logic [7:0]           standard_event_status;
    logic [7:0]           standard_event_enable_mask;
    logic [7:0]           service_request_enable;
    logic                 poll_request;
    logic                 master_prev;
    logic                 opc_armed;
    logic [ERR_CNT_W-1:0] err_count;
    logic                 resp_valid;
    logic                 resp_text;
    logic                 resp_last;
    logic [7:0]           resp_data;
    logic                 clr_pulse;
    logic                 rst_pulse;
    logic                 tst_pulse;
  } ctl_regs_t;

  ctl_regs_t  cur;
  ctl_regs_t  next_cur;
  logic [1:0] rst_sync;
  logic       rst_n;
  logic       accept;
  logic [7:0] ev_set;
  logic [7:0] status_byte;
  logic       master_sum;
  logic       event_clear;
  logic       poll_clear;
  ident_if    ident ();

  // Elaboration check on the error counter width
  // A one-bit counter would need a zero-width replication in the clear path
  if (ERR_CNT_W < 2 || ERR_CNT_W > 8)
  begin : g_bad_width
    $error("ERR_CNT_W must lie between 2 and 8");
  end

  // Reset release through two flops; assertion is immediate
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  ident_streamer #(
    .MAKER_TEXT (MAKER_TEXT),
    .MODEL_TEXT (MODEL_TEXT),
    .MFG_TEXT   (MFG_TEXT),
    .REV_MAJOR  (REV_MAJOR),
    .REV_MINOR  (REV_MINOR)
  ) u_ident (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .link     (ident.source)
  );

  // Only the idle state takes commands, so the opc query and streaming block the port
  assign cmd_ready = (cur.state == ST_IDLE); // [RULE10]
  assign accept = cmd_valid && cmd_ready;
  assign ident.start = accept && (cmd_code == CMD_IDENT_QUERY);
  assign ident.fw_updated = fw_updated;

  // Status byte summaries come straight from current state
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[SB_OPER] = oper_summary; // [RULE17]
    status_byte[SB_EVENT_SUM] = |(cur.standard_event_status &
                                  cur.standard_event_enable_mask & EV_USED_MASK); // [RULE3] [RULE19]
    status_byte[SB_MSG_AVAIL] = msg_available;
    status_byte[SB_QUES] = ques_summary;
    status_byte[SB_ERR_QUEUE] = (cur.err_count != '0);
    master_sum = |(status_byte & cur.service_request_enable & SRQ_WRITABLE); // [RULE18]
    status_byte[SB_MASTER] = master_sum; // [RULE14]
  end

  // Event sources for this cycle; error numbers classed by hundreds
  always_comb
  begin
    ev_set = 8'h00;
    if (err_valid)
    begin
      ev_set[EV_CMD_ERR] = (err_code >= ERR_CLASS_1) && (err_code < ERR_CLASS_2); // [RULE6]
      ev_set[EV_EXEC_ERR] = (err_code >= ERR_CLASS_2) && (err_code < ERR_CLASS_3); // [RULE6]
      ev_set[EV_DEV_ERR] = (err_code >= ERR_CLASS_3) && (err_code < ERR_CLASS_4); // [RULE7]
      ev_set[EV_QUERY_ERR] = (err_code >= ERR_CLASS_4) && (err_code < ERR_CLASS_5); // [RULE7]
    end
    if (reg_err_valid && ques_reg_bit)
      ev_set[EV_DEV_ERR] = 1'b1; // [RULE8]
    if (cur.opc_armed && !ops_pending)
      ev_set[EV_OP_DONE] = 1'b1; // [RULE9]
  end

  // Command decode and sequencing
  always_comb
  begin
    next_cur = cur;
    next_cur.resp_valid = 1'b0;
    next_cur.resp_text = 1'b0;
    next_cur.resp_last = 1'b0;
    next_cur.clr_pulse = 1'b0;
    next_cur.rst_pulse = 1'b0;
    next_cur.tst_pulse = 1'b0;
    event_clear = 1'b0;
    poll_clear = 1'b0;
    if (ev_set[EV_OP_DONE])
      next_cur.opc_armed = 1'b0;
    case (cur.state)
      ST_IDLE:
      begin
        if (accept)
        begin
          case (cmd_code)
            CMD_CLEAR_STATUS:
            begin
              event_clear = 1'b1; // [RULE1]
              poll_clear = 1'b1;
              next_cur.clr_pulse = 1'b1;
              next_cur.opc_armed = 1'b0;
            end
            CMD_EVENT_MASK_WRITE: next_cur.standard_event_enable_mask = cmd_arg; // [RULE2]
            CMD_EVENT_MASK_QUERY:
            begin
              next_cur.resp_valid = 1'b1;
              next_cur.resp_last = 1'b1;
              next_cur.resp_data = cur.standard_event_enable_mask; // [RULE2]
            end
            CMD_EVENT_STATUS_QUERY:
            begin
              next_cur.resp_valid = 1'b1;
              next_cur.resp_last = 1'b1;
              next_cur.resp_data = cur.standard_event_status; // [RULE5] [RULE13]
              event_clear = 1'b1;
            end
            CMD_IDENT_QUERY: next_cur.state = ST_IDENT;
            CMD_OPC_SET: next_cur.opc_armed = 1'b1; // [RULE9]
            CMD_OPC_QUERY: next_cur.state = ST_OPC_WAIT;
            CMD_RESET: next_cur.rst_pulse = 1'b1; // [RULE15]
            CMD_SRQ_MASK_WRITE: next_cur.service_request_enable = cmd_arg & SRQ_WRITABLE;
            CMD_SRQ_MASK_QUERY:
            begin
              next_cur.resp_valid = 1'b1;
              next_cur.resp_last = 1'b1;
              next_cur.resp_data = cur.service_request_enable;
            end
            CMD_STATUS_BYTE_QUERY:
            begin
              next_cur.resp_valid = 1'b1;
              next_cur.resp_last = 1'b1;
              next_cur.resp_data = status_byte; // [RULE14]
            end
            CMD_SERIAL_POLL:
            begin
              next_cur.resp_valid = 1'b1;
              next_cur.resp_last = 1'b1;
              next_cur.resp_data = status_byte;
              next_cur.resp_data[SB_MASTER] = cur.poll_request; // [RULE18]
              poll_clear = 1'b1;
            end
            CMD_SELF_TEST:
            begin
              next_cur.tst_pulse = 1'b1;
              next_cur.state = ST_TEST_WAIT;
            end
            default: next_cur.state = ST_IDLE;
          endcase
        end
      end
      ST_OPC_WAIT:
      begin
        // Later commands wait here until all output work has settled
        if (!ops_pending)
        begin
          next_cur.resp_valid = 1'b1; // [RULE10]
          next_cur.resp_text = 1'b1;
          next_cur.resp_last = 1'b1;
          next_cur.resp_data = ASCII_ONE;
          next_cur.state = ST_IDLE;
        end
      end
      ST_TEST_WAIT:
      begin
        if (selftest_done)
        begin
          next_cur.resp_valid = 1'b1;
          next_cur.resp_last = 1'b1;
          next_cur.resp_data = {7'h00, selftest_fail}; // [RULE16]
          next_cur.state = ST_IDLE;
        end
      end
      ST_IDENT:
      begin
        if (ident.valid)
        begin
          next_cur.resp_valid = 1'b1;
          next_cur.resp_text = 1'b1;
          next_cur.resp_last = ident.last;
          next_cur.resp_data = ident.data; // [RULE11]
          if (ident.last)
            next_cur.state = ST_IDLE;
        end
      end
      default: next_cur.state = ST_IDLE;
    endcase

    // New events win over a clear in the same cycle; unused bits stay zero
    next_cur.standard_event_status =
      ((event_clear ? 8'h00 : cur.standard_event_status) | ev_set) & EV_USED_MASK; // [RULE4] [RULE19]

    // Poll copy of the master summary latches on a rise, dropped by a poll
    next_cur.master_prev = master_sum;
    next_cur.poll_request = (cur.poll_request && !poll_clear) ||
                            (master_sum && !cur.master_prev); // [RULE18]

    // Error queue occupancy; a new error outlives a clear in the same cycle
    if (event_clear && poll_clear)
      next_cur.err_count = {{(ERR_CNT_W-1){1'b0}}, err_valid}; // [RULE1]
    else if (err_valid && !err_read && !(&cur.err_count))
      next_cur.err_count = cur.err_count + 1'b1;
    else if (err_read && !err_valid && (cur.err_count != '0))
      next_cur.err_count = cur.err_count - 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur <= '0;
      cur.state <= ST_IDLE;
      cur.standard_event_status <= EV_STATUS_RESET; // [RULE13]
      cur.standard_event_enable_mask <= EV_MASK_RESET; // [RULE2]
      cur.service_request_enable <= SRQ_MASK_RESET;
    end
    else
      cur <= next_cur;
  end

  assign resp_valid      = cur.resp_valid;
  assign resp_data       = cur.resp_data;
  assign resp_text       = cur.resp_text;
  assign resp_last       = cur.resp_last;
  assign clear_oper_ques = cur.clr_pulse; // Neighbouring trees clear their event registers
  assign reset_levels    = cur.rst_pulse; // Output off, zero volts, minimum current
  assign selftest_start  = cur.tst_pulse;
  assign service_request = cur.poll_request;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_cmd(cmd_t c);
    accept && cmd_code == c;
  endsequence
  sequence s_opcq_ready;
    s_cmd(CMD_OPC_QUERY) ##1 !ops_pending;
  endsequence

  property p_clear_status;
    s_cmd(CMD_CLEAR_STATUS) |=> cur.standard_event_status == $past(ev_set)
      && cur.standard_event_enable_mask == $past(cur.standard_event_enable_mask);
  endproperty
  a_clear_status: assert property (p_clear_status) else $error("clear-status failed"); // [RULE1]

  property p_mask_write;
    s_cmd(CMD_EVENT_MASK_WRITE) |=> cur.standard_event_enable_mask == $past(cmd_arg);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not stored"); // [RULE2]

  property p_summary;
    s_cmd(CMD_STATUS_BYTE_QUERY) |=> resp_valid && resp_data[SB_EVENT_SUM] ==
      |($past(cur.standard_event_status) & $past(cur.standard_event_enable_mask));
  endproperty
  a_summary: assert property (p_summary) else $error("event summary wrong"); // [RULE3]

  property p_unused_zero;
    cur.standard_event_status[6] == 1'b0 && cur.standard_event_status[1] == 1'b0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set"); // [RULE19]

  property p_read_clears;
    s_cmd(CMD_EVENT_STATUS_QUERY) |=> resp_data == $past(cur.standard_event_status)
      && cur.standard_event_status == $past(ev_set);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status read wrong"); // [RULE5]

  property p_cmd_error;
    err_valid && err_code >= 10'd100 && err_code < 10'd200 |=> cur.standard_event_status[5];
  endproperty
  a_cmd_error: assert property (p_cmd_error) else $error("1xx missed"); // [RULE6]

  property p_dev_error;
    (err_valid && err_code >= 10'd300 && err_code < 10'd400) || (reg_err_valid && ques_reg_bit)
      |=> cur.standard_event_status[3];
  endproperty
  a_dev_error: assert property (p_dev_error) else $error("device error missed"); // [RULE8]

  property p_opc_done;
    cur.opc_armed && !ops_pending && !(accept && cmd_code == CMD_OPC_SET)
      |=> cur.standard_event_status[0] && !cur.opc_armed;
  endproperty
  a_opc_done: assert property (p_opc_done) else $error("opc bit not set"); // [RULE9]

  property p_opc_query;
    s_opcq_ready |=> resp_valid && resp_text && resp_data == ASCII_ONE && cmd_ready;
  endproperty
  a_opc_query: assert property (p_opc_query) else $error("opc answer wrong"); // [RULE10]

  property p_power_on;
    $rose(rst_n) |-> cur.standard_event_status == 8'h80;
  endproperty
  a_power_on: assert property (p_power_on) else $error("power-on bit lost"); // [RULE13]

  property p_self_test;
    cur.state == ST_TEST_WAIT && selftest_done |=> resp_valid
      && resp_data == {7'h00, $past(selftest_fail)} && cmd_ready;
  endproperty
  a_self_test: assert property (p_self_test) else $error("self-test answer wrong"); // [RULE16]

  property p_poll_clear;
    s_cmd(CMD_SERIAL_POLL) ##0 !(master_sum && !cur.master_prev) |=> !service_request;
  endproperty
  a_poll_clear: assert property (p_poll_clear) else $error("poll did not clear"); // [RULE18]

endmodule

//--- testbench/supply_model.sv
// Model of the supply's test engine behind the self-test handshake.
// Assumes start is a one-cycle pulse on core_clk.
`timescale 1ns/1ps
module supply_model #(parameter int unsigned TEST_CYCLES = 6)
(
  // Clock
  input  wire logic core_clk,
  // Handshake with the core
  input  wire logic start,
  input  wire logic fail_mode,
  output logic      done,
  output logic      fail
);
  int unsigned cnt;

  // Answer after a fixed run; fail toggles between answers so no stale value is read
  always @(posedge core_clk)
  begin
    done <= 1'b0;
    fail <= ~fail;
    if (start)
      cnt <= TEST_CYCLES;
    else if (cnt == 1)
    begin
      done <= 1'b1;
      fail <= fail_mode;
      cnt  <= 0;
    end
    else if (cnt != 0)
      cnt <= cnt - 1;
  end

  initial
  begin
    cnt  = 0;
    done = 1'b0;
    fail = 1'b0;
  end
endmodule

//--- testbench/tb.sv
// Self-checking bench for the status-reporting core.
// Assumes a 125 MHz core_clk and commands offered at rising edges.
`timescale 1ns/1ps
module tb;
  import status_pkg::*;
  typedef struct packed {logic [9:0] code; logic reg_err; logic ques; logic [7:0] exp;} row_t;
  logic       core_clk, reset_n, cmd_valid, err_valid, reg_err_valid, ques_reg_bit;
  logic       ops_pending, fw_updated, test_fail, st_start, st_done, st_fail, srq;
  logic       cmd_ready, resp_valid, resp_text, resp_last, cls_pulse, rst_pulse;
  cmd_t       cmd_code;
  logic [7:0] cmd_arg, resp_data;
  logic [9:0] err_code;
  logic [7:0] rx [64];
  logic       rx_txt;
  logic [2:0] sums;
  int         rx_n, waited, mismatches, comparisons;
  int         cls_seen = 0, rst_seen = 0;
  // Error classes at both ends of each range, then regulation errors
  row_t rows [10] = '{'{10'd100, 1'b0, 1'b0, 8'h20}, '{10'd199, 1'b0, 1'b0, 8'h20},
    '{10'd200, 1'b0, 1'b0, 8'h10}, '{10'd299, 1'b0, 1'b0, 8'h10},
    '{10'd300, 1'b0, 1'b0, 8'h08}, '{10'd399, 1'b0, 1'b0, 8'h08},
    '{10'd400, 1'b0, 1'b0, 8'h04}, '{10'd499, 1'b0, 1'b0, 8'h04},
    '{10'd0, 1'b1, 1'b1, 8'h08}, '{10'd0, 1'b1, 1'b0, 8'h00}};

  ieee488_status_reporting dut_u (.core_clk(core_clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_text(resp_text),
    .resp_last(resp_last), .err_valid(err_valid), .err_code(err_code), .err_read(1'b0),
    .reg_err_valid(reg_err_valid), .ques_reg_bit(ques_reg_bit), .oper_summary(sums[2]),
    .ques_summary(sums[1]), .msg_available(sums[0]), .ops_pending(ops_pending),
    .fw_updated(fw_updated), .clear_oper_ques(cls_pulse), .reset_levels(rst_pulse),
    .selftest_start(st_start), .selftest_done(st_done), .selftest_fail(st_fail),
    .service_request(srq));
  supply_model model_u (.core_clk(core_clk), .start(st_start), .fail_mode(test_fail),
    .done(st_done), .fail(st_fail));

  // Count action pulses; they are too short to catch from the main sequence
  always @(posedge core_clk)
  begin
    cls_seen <= cls_seen + int'(cls_pulse === 1'b1);
    rst_seen <= rst_seen + int'(rst_pulse === 1'b1);
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Offer a command, hold it until taken, then gather answer bytes up to the last
  task automatic do_cmd(input cmd_t c, input logic [7:0] a, input bit resp);
    waited = 0;
    rx_n = 0;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    cmd_arg   <= a;
    do @(negedge core_clk); while (cmd_ready !== 1'b1 && ++waited < 1000);
    if (waited >= 1000) mismatches++;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    waited = 0;
    while (resp && waited < 1000 && rx_n < 64)
    begin
      @(negedge core_clk);
      waited++;
      if (resp_valid === 1'b1)
      begin
        rx[rx_n] = resp_data;
        rx_txt = resp_text;
        rx_n++;
        if (resp_last === 1'b1)
          break;
      end
    end
    if (waited >= 1000) mismatches++;
  endtask

  task automatic q(input cmd_t c, input logic [7:0] a, input logic [7:0] exp);
    do_cmd(c, a, 1'b1);
    check(rx[0], exp);
  endtask

  task automatic ev(input logic [9:0] code, input logic r, input logic qb);
    @(posedge core_clk);
    err_valid     <= (code != 10'd0);
    err_code      <= code;
    reg_err_valid <= r;
    ques_reg_bit  <= qb;
    @(posedge core_clk);
    err_valid     <= 1'b0;
    reg_err_valid <= 1'b0;
  endtask

  task automatic give_verdict;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Hang guard, well past the few hundred cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    give_verdict();
  end

  initial
  begin
    {reset_n, cmd_valid, err_valid, reg_err_valid, ques_reg_bit} = '0;
    {ops_pending, fw_updated, test_fail, cmd_arg, err_code, sums} = '0;
    {mismatches, comparisons} = '0;
    cmd_code = CMD_CLEAR_STATUS;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    q(CMD_EVENT_STATUS_QUERY, 8'h00, 8'h80);
    q(CMD_EVENT_STATUS_QUERY, 8'h00, 8'h00);
    q(CMD_EVENT_MASK_QUERY, 8'h00, 8'h00);
    foreach (rows[i])
    begin
      ev(rows[i].code, rows[i].reg_err, rows[i].ques);
      q(CMD_EVENT_STATUS_QUERY, 8'h00, rows[i].exp);
    end
    // Summary with the command error masked out, then enabled
    do_cmd(CMD_CLEAR_STATUS, 8'h00, 1'b0);
    do_cmd(CMD_EVENT_MASK_WRITE, 8'hdf, 1'b0);
    do_cmd(CMD_SRQ_MASK_WRITE, 8'h20, 1'b0);
    ev(10'd150, 1'b0, 1'b0);
    q(CMD_STATUS_BYTE_QUERY, 8'h00, 8'h04);
    do_cmd(CMD_EVENT_MASK_WRITE, 8'hff, 1'b0);
    q(CMD_EVENT_MASK_QUERY, 8'h00, 8'hff);
    q(CMD_STATUS_BYTE_QUERY, 8'h00, 8'h64);
    q(CMD_STATUS_BYTE_QUERY, 8'h00, 8'h64);
    check({7'h0, srq}, 8'h01);
    q(CMD_SERIAL_POLL, 8'h00, 8'h64);
    check({7'h0, srq}, 8'h00);
    q(CMD_STATUS_BYTE_QUERY, 8'h00, 8'h64);
    do_cmd(CMD_CLEAR_STATUS, 8'h00, 1'b0);
    q(CMD_STATUS_BYTE_QUERY, 8'h00, 8'h00);
    q(CMD_EVENT_STATUS_QUERY, 8'h00, 8'h00);
    q(CMD_EVENT_MASK_QUERY, 8'h00, 8'hff);
    q(CMD_SRQ_MASK_QUERY, 8'h00, 8'h20);
    check(cls_seen[7:0], 8'h02);
    // Neighbouring summaries land on status byte bits 7, 4 and 3
    @(posedge core_clk);
    sums <= 3'b111;
    q(CMD_STATUS_BYTE_QUERY, 8'h00, 8'h98);
    @(posedge core_clk);
    sums <= 3'b000;
    // Completion flag waits for pending work while later commands still run
    @(posedge core_clk);
    ops_pending <= 1'b1;
    do_cmd(CMD_OPC_SET, 8'h00, 1'b0);
    q(CMD_EVENT_STATUS_QUERY, 8'h00, 8'h00);
    @(posedge core_clk);
    ops_pending <= 1'b0;
    repeat (4) @(posedge core_clk);
    q(CMD_EVENT_STATUS_QUERY, 8'h00, 8'h01);
    @(posedge core_clk);
    ops_pending <= 1'b1;
    fork
      do_cmd(CMD_OPC_QUERY, 8'h00, 1'b1);
      begin
        repeat (20) @(posedge core_clk);
        ops_pending <= 1'b0;
      end
    join
    check(rx[0], ASCII_ONE);
    check({6'h0, rx_txt, waited > 15}, 8'h03);
    for (int f = 0; f < 2; f++)
    begin
      @(posedge core_clk);
      fw_updated <= f[0];
      test_fail  <= f[0];
      do_cmd(CMD_IDENT_QUERY, 8'h00, 1'b1);
      check(rx_n[7:0], 8'd47);
      check(rx[8], 8'h2c);
      check(rx[25], 8'h2c);
      check(rx[41], 8'h2c);
      check(rx[34], 8'h2d);
      check(rx[42], f ? "v" : "V");
      q(CMD_SELF_TEST, 8'h00, {7'h0, f[0]});
    end
    do_cmd(CMD_RESET, 8'h00, 1'b0);
    repeat (3) @(posedge core_clk);
    check(rst_seen[7:0], 8'h01);
    // Mid-run reset brings back the power-on bit and a cleared mask
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    q(CMD_EVENT_MASK_QUERY, 8'h00, 8'h00);
    q(CMD_EVENT_STATUS_QUERY, 8'h00, 8'h80);
    give_verdict();
  end
endmodule
